/* hdl/tws_fifo.v */
// Write-word buffer with registered output stage
`timescale 1ns/1ps
module tws_fifo #(
   parameter W = 16,
   parameter D = 16,
   parameter AW = 4
)
(
   input wire core_clk, // Core clock
   input wire nrst, // Asynchronous reset, active low
   input wire ce, // Clock enable
   input wire in_valid, // Word offered
   output wire in_ready, // Room for a word
   input wire [W-1:0] in_data, // Word in
   output reg out_valid, // Output word valid
   input wire out_ready, // Consumer takes the word
   output reg [W-1:0] out_data // Word out
);
   reg [W-1:0] mem_r [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push;
   wire load;

   // Full when all store entries are taken
   assign in_ready = (cnt_r != D[AW:0]);
   assign push = in_valid & in_ready;
   assign load = (cnt_r != {(AW+1){1'b0}}) & (~out_valid | out_ready);

   // Store words by write index
   always @(posedge core_clk)
   begin
      if (ce && push)
      begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Pointers, fill count and output stage
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data <= {W{1'b0}};
      end
      else if (ce)
      begin
         if (push)
         begin
            wp_r <= wp_r + 1'b1;
         end
         if (load)
         begin
            rp_r <= rp_r + 1'b1;
            out_data <= mem_r[rp_r];
            out_valid <= 1'b1;
         end
         else if (out_ready)
         begin
            out_valid <= 1'b0;
         end
         if (push && !load)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (load && !push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // tws_fifo

/* hdl/tws_regs.vh */
// Constants for the two-wire register slave port
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// Chip address, seven bits, and where the two select pins land in it
`define TWS_DEV_ADDR 7'h38
`define TWS_SEL_LSB 1
// Register pointer value after any reset
`define TWS_PTR_RESET 8'h00
// Bit counter: last data bit index and acknowledge slot index
`define TWS_BIT_LAST 4'h7
`define TWS_BIT_ACK 4'h8
// Samples a line must hold before the filter accepts a new level
`define TWS_FILT_LEN 3
// Write buffer: register pointer byte plus data byte per word
`define TWS_FIFO_WIDTH 16
`define TWS_FIFO_DEPTH 16
`define TWS_FIFO_AW 4
// Idle level of synchronised pins: reg reset, sel1, sel0, sda, scl
`define TWS_PIN_IDLE 5'h1f

`endif

/* hdl/tws_slave.v */
// Two-wire slave port giving a bus master byte access to internal registers
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_slave #(
   parameter FILT_LEN = `TWS_FILT_LEN,
   parameter FIFO_DEPTH = `TWS_FIFO_DEPTH,
   parameter FIFO_AW = `TWS_FIFO_AW
)
(
   input wire core_clk, // Core clock, 200 MHz
   input wire nrst, // Asynchronous reset, active low
   input wire ce, // Clock enable, freezes all state when low
   input wire scl_i, // Bus clock line level
   input wire sda_i, // Bus data line level
   output reg sda_o, // Data line drive value, always low
   output reg sda_oe, // Data line pulled low while high
   input wire array_select_pin_0, // Select pin 0
   input wire array_select_pin_1, // Select pin 1
   input wire addr_sel_en, // Global control bit 6 from register file
   input wire reg_rst_pin_n, // Register reset pin, active low
   output wire regs_rst_n, // Register file reset, active low
   output wire reg_wr_valid, // Register write request
   input wire reg_wr_ready, // Register file accepts write
   output wire [7:0] reg_wr_addr, // Register write index
   output wire [7:0] reg_wr_data, // Register write data
   output reg [7:0] reg_rd_addr, // Register read index, the pointer
   input wire [7:0] reg_rd_data, // Register read data, next cycle
   output reg bus_busy // Bus between start and stop
);
   // One-hot transfer states
   localparam [3:0] ST_LISTEN = 4'b0001;
   localparam [3:0] ST_ADACK = 4'b0010;
   localparam [3:0] ST_RX = 4'b0100;
   localparam [3:0] ST_TX = 4'b1000;

   wire [4:0] pin_f;
   wire scl_f;
   wire sda_f;
   wire [1:0] sel_f;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire [7:0] byte_in;
   wire addr_hit;
   wire fifo_in_ready;
   wire fifo_push;
   wire [15:0] fifo_out;
   reg scl_d_r;
   reg sda_d_r;
   reg [3:0] state_r;
   reg [3:0] cnt_r;
   reg [7:0] sh_r;
   reg [7:0] tx_r;
   reg ptr_phase_r;
   reg ack_pend_r;
   reg rw_r;

   // Chip address, optionally steered by the select pins
   function [6:0] tws_chip_addr;
      input en;
      input [1:0] sel;
      begin
         tws_chip_addr = `TWS_DEV_ADDR;
         if (en)
         begin
            tws_chip_addr = `TWS_DEV_ADDR | ({5'h00, sel} << `TWS_SEL_LSB);
         end
      end
   endfunction

   // Pointer step after each byte moved
   // Wraps from the top register back to zero
   function [7:0] tws_ptr_inc;
      input [7:0] p;
      begin
         tws_ptr_inc = p + 8'h01;
      end
   endfunction

   // Synchronise and filter every pin before use
   tws_sync_filt #(
      .W(5),
      .FILT(FILT_LEN),
      .IDLE(`TWS_PIN_IDLE)
   ) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .pin_in({reg_rst_pin_n, array_select_pin_1, array_select_pin_0, sda_i, scl_i}),
      .pin_out(pin_f)
   );

   assign scl_f = pin_f[0];
   assign sda_f = pin_f[1];
   assign sel_f = pin_f[3:2];
   // Register reset level goes straight from the filter flop
   assign regs_rst_n = pin_f[4];

   // Line events from filtered levels
   assign scl_rise = scl_f & ~scl_d_r;
   assign scl_fall = ~scl_f & scl_d_r;
   // Start and stop want SCL high in this sample and the one before
   assign start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
   assign stop_det = scl_f & scl_d_r & ~sda_d_r & sda_f;

   // Byte as it completes on the eighth rising edge, MSB first
   assign byte_in = {sh_r[6:0], sda_f};
   // Select pins reach the address only through the filter flops
   assign addr_hit = (byte_in[7:1] == tws_chip_addr(addr_sel_en, sel_f));

   // Data byte of a write goes into the buffer if it has room
   assign fifo_push = scl_rise & (state_r == ST_RX) & (cnt_r == `TWS_BIT_LAST)
      & ~ptr_phase_r & fifo_in_ready;

   // Write words wait here until the register file takes them
   // Holds sixteen stored words plus one in the output stage
   tws_fifo #(
      .W(`TWS_FIFO_WIDTH),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data({reg_rd_addr, byte_in}),
      .out_valid(reg_wr_valid),
      .out_ready(reg_wr_ready),
      .out_data(fifo_out)
   );

   assign reg_wr_addr = fifo_out[15:8];
   assign reg_wr_data = fifo_out[7:0];

   // Previous line levels for edge finding
   // Reset to the idle high level so leaving reset shows no false edge
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else if (ce)
      begin
         scl_d_r <= scl_f;
         sda_d_r <= sda_f;
      end
   end

   // Busy flag between start and stop
   // Start and stop need opposite data edges, so they never meet in one cycle
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_busy <= 1'b0;
      end
      else if (ce)
      begin
         if (start_det)
         begin
            bus_busy <= 1'b1;
         end
         else if (stop_det)
         begin
            bus_busy <= 1'b0;
         end
      end
   end

   // Register pointer: set, stepped, cleared by register reset
   // A read steps it as well, even on the byte the master refuses
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         reg_rd_addr <= `TWS_PTR_RESET;
      end
      else if (ce)
      begin
         if (!regs_rst_n)
         begin
            reg_rd_addr <= `TWS_PTR_RESET;
         end
         else if (scl_rise && cnt_r == `TWS_BIT_LAST)
         begin
            if (state_r == ST_RX && ptr_phase_r)
            begin
               reg_rd_addr <= byte_in;
            end
            else if (fifo_push || state_r == ST_TX)
            begin
               reg_rd_addr <= tws_ptr_inc(reg_rd_addr);
            end
         end
      end
   end

   // Bit engine, address match, acknowledge and transmit
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= ST_LISTEN;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_phase_r <= 1'b0;
         ack_pend_r <= 1'b0;
         rw_r <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
      end
      else if (ce)
      begin
         sda_o <= 1'b0;
         if (start_det || stop_det)
         begin
            // Any start or stop restarts byte framing and frees the line
            // A stale pointer phase is harmless: every write header sets it again
            state_r <= ST_LISTEN;
            cnt_r <= 4'h0;
            ack_pend_r <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (scl_rise)
         begin
            sh_r <= byte_in;
            if (cnt_r == `TWS_BIT_ACK)
            begin
               cnt_r <= 4'h0;
               if (state_r == ST_TX && sda_f)
               begin
                  state_r <= ST_LISTEN;
               end
            end
            else
            begin
               cnt_r <= cnt_r + 4'h1;
            end
            if (cnt_r == `TWS_BIT_LAST)
            begin
               case (state_r)
                  ST_LISTEN:
                  begin
                     // Matches with or without a start before it
                     // Only while listening, so bytes received in ST_RX or ST_TX never match
                     ack_pend_r <= addr_hit;
                     rw_r <= byte_in[0];
                  end
                  ST_RX:
                  begin
                     // Full buffer refuses the data byte with no-acknowledge
                     ack_pend_r <= ptr_phase_r | fifo_in_ready;
                     ptr_phase_r <= 1'b0;
                  end
                  default:
                  begin
                     ack_pend_r <= 1'b0;
                  end
               endcase
            end
         end
         else if (scl_fall)
         begin
            if (cnt_r == `TWS_BIT_ACK)
            begin
               // Acknowledge slot opens: receiver pulls low, sender lets go
               sda_oe <= ack_pend_r & (state_r != ST_TX);
               if (state_r == ST_LISTEN && ack_pend_r)
               begin
                  state_r <= ST_ADACK;
               end
            end
            else if (cnt_r == 4'h0)
            begin
               ack_pend_r <= 1'b0;
               case (state_r)
                  ST_ADACK:
                  begin
                     if (rw_r)
                     begin
                        state_r <= ST_TX;
                        tx_r <= reg_rd_data;
                        sda_oe <= ~reg_rd_data[7];
                     end
                     else
                     begin
                        state_r <= ST_RX;
                        ptr_phase_r <= 1'b1;
                        sda_oe <= 1'b0;
                     end
                  end
                  ST_TX:
                  begin
                     // Master acknowledged: next byte from the pointer
                     tx_r <= reg_rd_data;
                     sda_oe <= ~reg_rd_data[7];
                  end
                  default:
                  begin
                     sda_oe <= 1'b0;
                  end
               endcase
            end
            else if (state_r == ST_TX)
            begin
               // Next bit placed while the clock is low
               // The last bit is let go at the acknowledge slot fall
               tx_r <= {tx_r[6:0], 1'b0};
               sda_oe <= ~tx_r[6];
            end
         end
      end
   end
endmodule // tws_slave

/* hdl/tws_sync_filt.v */
// Two-flop synchroniser with a stable-level glitch filter per bit
`timescale 1ns/1ps
module tws_sync_filt #(
   parameter W = 5,
   parameter FILT = 3,
   parameter [W-1:0] IDLE = {W{1'b1}}
)
(
   input wire core_clk, // Core clock
   input wire nrst, // Asynchronous reset, active low
   input wire ce, // Clock enable
   input wire [W-1:0] pin_in, // Raw asynchronous inputs
   output reg [W-1:0] pin_out // Synchronised, filtered levels
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W*FILT-1:0] hist_r;
   reg [W-1:0] all1;
   reg [W-1:0] all0;
   integer i;
   integer k;

   // Per bit: does the whole history agree on one level
   always @*
   begin
      all1 = {W{1'b1}};
      all0 = {W{1'b1}};
      for (i = 0; i < W; i = i + 1)
      begin
         for (k = 0; k < FILT; k = k + 1)
         begin
            all1[i] = all1[i] & hist_r[k*W+i];
            all0[i] = all0[i] & ~hist_r[k*W+i];
         end
      end
   end

   // Sync stages, history shift and filtered output
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_r <= IDLE;
         s2_r <= IDLE;
         hist_r <= {FILT{IDLE}};
         pin_out <= IDLE;
      end
      else if (ce)
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         hist_r <= {hist_r[W*(FILT-1)-1:0], s2_r};
         pin_out <= (pin_out | all1) & ~all0;
      end
   end
endmodule // tws_sync_filt

/* testbench/tb_tws_slave.sv */
// Self-checking bench for the two-wire register slave port
`timescale 1ns/1ps
module tb_tws_slave;
   reg core_clk, nrst, ce, sel0, sel1, addr_sel_en, reg_rst_pin_n, reg_wr_ready, hold_r;
   wire scl_i, sda_i, sda_o, sda_oe, regs_rst_n, reg_wr_valid, bus_busy;
   wire [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr;
   reg [7:0] reg_rd_data, rb, d;
   reg [7:0] mem [0:255];
   reg [15:0] exp_q [$];
   reg [31:0] rnd, rr;
   reg a;
   integer fails, compares, seed, i, j, k;
   // One slave alone on the bus
   tws_slave u_tws_slave (.core_clk(core_clk), .nrst(nrst), .ce(ce), .scl_i(scl_i),
      .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .array_select_pin_0(sel0),
      .array_select_pin_1(sel1), .addr_sel_en(addr_sel_en), .reg_rst_pin_n(reg_rst_pin_n),
      .regs_rst_n(regs_rst_n), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
      .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
      .reg_rd_data(reg_rd_data), .bus_busy(bus_busy));
   tws_master_model u_mst (.core_clk(core_clk), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   function [7:0] dflt(input [7:0] x);
      dflt = x ^ 8'h5a;
   endfunction
   // Register file model: defaults on reset, writes, read data a cycle on
   always @(posedge core_clk)
   begin
      rr = $random(seed);
      if (!regs_rst_n)
         for (j = 0; j < 256; j = j + 1) mem[j] <= dflt(j);
      else if (reg_wr_valid && reg_wr_ready)
         mem[reg_wr_addr] <= reg_wr_data;
      reg_rd_data <= mem[reg_rd_addr];
      reg_wr_ready <= hold_r ? 1'b0 : rr[0];
   end
   // Each accepted write is matched against the oldest noted word
   always @(posedge core_clk)
      if (nrst && reg_wr_valid && reg_wr_ready)
         chk({reg_wr_addr, reg_wr_data}, exp_q.pop_front());
   task chk(input [15:0] got, input [15:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task hdr(input [6:0] ad, input rw, input ack);
   begin
      u_mst.start;
      chk(bus_busy, 1'b1);
      u_mst.xfer({ad, rw}, 1'b1, rb, a);
      chk(a, !ack);
   end
   endtask
   // Pointer then n data bytes; bytes from lim on must be refused
   task wr(input [7:0] ptr, input integer n, input integer lim);
   begin
      hdr(7'h38, 1'b0, 1'b1);
      u_mst.xfer(ptr, 1'b1, rb, a);
      chk(a, 1'b0);
      for (i = 0; i < n; i = i + 1)
      begin
         rnd = $random(seed);
         d = rnd[7:0];
         if (i < lim)
            exp_q.push_back({ptr + i[7:0], d});
         u_mst.xfer(d, 1'b1, rb, a);
         chk(a, i >= lim);
      end
      u_mst.stop;
   end
   endtask
   task rd(input [7:0] ptr, input integer n);
   begin
      hdr(7'h38, 1'b1, 1'b1);
      for (i = 0; i < n; i = i + 1)
      begin
         u_mst.xfer(8'hff, i == n - 1, rb, a);
         chk(rb, dflt(ptr + i[7:0]));
      end
      u_mst.stop;
      chk(sda_oe, 1'b0);
      chk(bus_busy, 1'b0);
   end
   endtask
   task drain;
   begin
      k = 0;
      while ((exp_q.size() > 0 || reg_wr_valid !== 1'b0) && k < 3000)
      begin
         @(posedge core_clk);
         k = k + 1;
      end
      chk(k < 3000, 1'b1);
   end
   endtask
   task test_done;
   begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (95000) @(posedge core_clk);
      fails = fails + 1;
      test_done;
   end
   initial
   begin
      seed = 79;
      fails = 0;
      compares = 0;
      {nrst, ce, sel0, sel1, addr_sel_en, reg_rst_pin_n, reg_wr_ready, hold_r} = 8'h44;
      for (k = 0; k < 256; k = k + 1) mem[k] = dflt(k);
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (20) @(posedge core_clk);
      rd(8'h00, 3);
      wr(8'hfe, 4, 255);
      drain;
      wr(8'h41, 0, 255);
      rd(8'h41, 2);
      hold_r <= 1'b1;
      wr(8'h10, 18, 17);
      hold_r <= 1'b0;
      drain;
      hdr(7'h39, 1'b0, 1'b0);
      u_mst.stop;
      u_mst.glitch;
      chk(bus_busy, 1'b0);
      addr_sel_en <= 1'b1;
      for (k = 0; k < 4; k = k + 1)
      begin
         {sel1, sel0} <= k[1:0];
         repeat (20) @(posedge core_clk);
         hdr(7'h38 | {k[1:0], 1'b0}, 1'b0, 1'b1);
         u_mst.stop;
         hdr(7'h38, 1'b0, k == 0);
         u_mst.stop;
      end
      {addr_sel_en, sel1, sel0} <= 3'h0;
      u_mst.lower;
      u_mst.xfer(8'h70, 1'b1, rb, a);
      chk(a, 1'b0);
      u_mst.stop;
      wr(8'h05, 1, 255);
      drain;
      reg_rst_pin_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      reg_rst_pin_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      rd(8'h00, 7);
      test_done;
   end
endmodule // tb_tws_slave

/* testbench/tws_master_model.sv */
// Bus master model for the clock and data lines
`timescale 1ns/1ps
module tws_master_model (
   input wire core_clk, // Core clock for pacing
   input wire sda_oe, // Slave pulls data low
   output reg scl_i, // Clock line level
   output wire sda_i // Data line level
);
   reg sda_low_r; // Master pulls data low
   // Open-drain wire with pull-up
   assign sda_i = ~(sda_low_r | sda_oe);
   initial
   begin
      scl_i = 1'b1;
      sda_low_r = 1'b0;
   end
   task wt(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // One pulse of 125 ns; data set in low phase, sampled at end of high
   task bit_io(input b, output r);
   begin
      wt(6);
      sda_low_r <= ~b;
      wt(6);
      scl_i <= 1'b1;
      wt(13);
      r = sda_i;
      scl_i <= 1'b0;
   end
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task xfer(input [7:0] d, input m_ack, output [7:0] r, output a);
      integer i;
      reg b;
   begin
      for (i = 7; i >= 0; i = i - 1)
      begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(m_ack, a);
   end
   endtask
   task start;
   begin
      wt(6);
      sda_low_r <= 1'b0;
      wt(6);
      scl_i <= 1'b1;
      wt(12);
      sda_low_r <= 1'b1;
      wt(12);
      scl_i <= 1'b0;
   end
   endtask
   task stop;
   begin
      wt(6);
      sda_low_r <= 1'b1;
      wt(6);
      scl_i <= 1'b1;
      wt(12);
      sda_low_r <= 1'b0;
      wt(12);
   end
   endtask
   // Short low pulse on the data line, below the filter length
   task glitch;
   begin
      wt(6);
      sda_low_r <= 1'b1;
      wt(2);
      sda_low_r <= 1'b0;
      wt(12);
   end
   endtask
   // Clock low from idle, to clock bits without a start
   task lower;
   begin
      wt(6);
      scl_i <= 1'b0;
   end
   endtask
endmodule // tws_master_model

/* testbench/tws_slave_properties.sv */
// Concurrent checks on the two-wire slave ports
`timescale 1ns/1ps
module tws_slave_properties (
   input wire core_clk, // Core clock
   input wire nrst, // Reset, active low
   input wire scl_i, // Clock line
   input wire sda_i, // Data line
   input wire sda_o, // Data drive value
   input wire sda_oe, // Data pull enable
   input wire reg_rst_pin_n, // Register reset pin
   input wire regs_rst_n, // Register file reset
   input wire reg_wr_valid, // Write request
   input wire reg_wr_ready, // Write accept
   input wire [7:0] reg_wr_addr, // Write index
   input wire [7:0] reg_wr_data, // Write data
   input wire [7:0] reg_rd_addr, // Pointer
   input wire bus_busy // Bus busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Reset pin held long enough to pass the filter
   sequence s_pin_low;
      !reg_rst_pin_n [*8];
   endsequence
   sequence s_pin_high;
      reg_rst_pin_n [*8];
   endsequence
   property p_drive_low;
      sda_o == 1'b0;
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("drive not low");
   property p_busy_on;
      $rose(bus_busy) |-> scl_i && !sda_i;
   endproperty
   a_busy_on: assert property (p_busy_on) else $error("busy without start");
   property p_busy_off;
      $fell(bus_busy) |-> scl_i && sda_i;
   endproperty
   a_busy_off: assert property (p_busy_off) else $error("free without stop");
   property p_oe_low_phase;
      $changed(sda_oe) |-> !scl_i;
   endproperty
   a_oe_low_phase: assert property (p_oe_low_phase) else $error("data moved in high");
   property p_wr_hold;
      reg_wr_valid && !reg_wr_ready |=> reg_wr_valid && $stable(reg_wr_addr)
         && $stable(reg_wr_data);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write word dropped");
   property p_rst_on;
      s_pin_low |-> !regs_rst_n;
   endproperty
   a_rst_on: assert property (p_rst_on) else $error("register reset missed");
   property p_rst_off;
      s_pin_high |-> regs_rst_n;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("spurious register reset");
   property p_ptr_zero;
      !regs_rst_n [*3] |-> reg_rd_addr == 8'h00;
   endproperty
   a_ptr_zero: assert property (p_ptr_zero) else $error("pointer not cleared");
   property p_stop_release;
      $fell(bus_busy) |-> !sda_oe;
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("held after stop");
endmodule // tws_slave_properties
bind tws_slave tws_slave_properties u_props (.core_clk(core_clk), .nrst(nrst),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .reg_rst_pin_n(reg_rst_pin_n), .regs_rst_n(regs_rst_n), .reg_wr_valid(reg_wr_valid),
   .reg_wr_ready(reg_wr_ready), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
   .reg_rd_addr(reg_rd_addr), .bus_busy(bus_busy));
